// *** rtl/scpm_param_bank.sv ***
// Servo common parameter bank: answers parameter read and write commands.
// Assumes a command decoder on clk feeds requests and the config pulse.
`default_nettype none

// Operation
// - Common parameter 92h reads a fixed output-signal capability word.
// - Common parameter 93h reads a fixed input-signal capability word.
// - Bus number minus 2000h selects the drive parameter.
// - Drive parameters move only through read and write commands.
// - Immediate parameters take a written value at once.
// - Deferred parameters take effect after the config command.
// - Common 21h and 22h alias gear drive parameters 20Eh and 210h.
// - Common 61h to 67h alias the adjustment drive parameters.
// - Common 84h to 86h alias homing drive parameters, 84h and 85h by motor kind.
// - Common 8Ch to 8Fh alias torque limit and speed range parameters.
// - Common 1h-Ch and 41h-49h are served locally, no drive parameter.
// - Common 90h and 91h report supported command field bits.
// - Common 89h and 8Ah select the two selectable monitors.
module scpm_param_bank
  import scpm_pkg::*;
#(
  parameter int          DEPTH    = scpm_pkg::SCPM_PT_DEPTH,
  parameter logic [31:0] CTRL_CAP = 32'h00000000,
  parameter logic [31:0] STAT_CAP = 32'h00000000
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 req_valid,
  input  wire scpm_pkg::scpm_req_s  req,
  output var  logic                 req_ready,
  output var  logic                 rsp_valid,
  output var  scpm_pkg::scpm_rsp_s  rsp,
  input  wire logic                 cfg_valid,
  input  wire logic                 motor_linear,
  input  wire logic [11:0][31:0]    dev_info,
  output var  logic                 apply_valid,
  output var  scpm_pkg::scpm_apply_s apply,
  output var  logic [31:0]          sel_mon_one,
  output var  logic [31:0]          sel_mon_two
);
  import scpm_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_MEMRD, S_FLUSH} scpm_state_e;

  scpm_state_e  state_q;
  scpm_req_s    req_q;
  logic         lin_q;
  logic         rsp_valid_q;
  scpm_rsp_s    rsp_q;
  logic         apply_valid_q;
  scpm_apply_s  apply_q;
  logic         cfg_pend_q;
  logic [1:0]   gear_pend_q;
  logic [31:0]  gear_stage_q [2];
  logic [31:0]  loc_q [SCPM_SLOTS];
  logic [31:0]  mem_rdata;
  logic         req_fire;

  // Decode of the captured request
  logic         d_err;
  logic         d_ro;
  logic         d_mem;
  logic         d_loc;
  logic         d_defer;
  logic [10:0]  d_pt;
  logic [3:0]   d_slot;
  logic [31:0]  d_rdata;
  logic [15:0]  d_off;
  scpm_alias_s  d_alias;

  assign req_ready = (state_q == S_IDLE) && !cfg_pend_q;
  assign req_fire  = req_valid && req_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Number decode: drive range, alias table, local and constant words
  always_comb begin
    d_err   = 1'b0;
    d_ro    = 1'b0;
    d_mem   = 1'b0;
    d_loc   = 1'b0;
    d_pt    = 11'h000;
    d_slot  = 4'h0;
    d_rdata = 32'h00000000;
    d_off   = req_q.num - SCPM_PT_BASE;
    d_alias = scpm_alias(req_q.num[7:0], lin_q);
    if (req_q.num >= SCPM_PT_BASE && 32'(d_off) < DEPTH) begin
      d_mem = 1'b1;
      d_pt  = d_off[10:0];
    end else if (req_q.num[15:8] != 8'h00) begin
      d_err = 1'b1;
    end else if (d_alias.hit) begin
      d_mem = 1'b1;
      d_pt  = d_alias.pt;
    end else begin
      case (req_q.num[7:0])
        SCPM_CP_OUTCAP: begin
          d_ro    = 1'b1;
          d_rdata = SCPM_OUT_CAP_RST;
        end
        SCPM_CP_INCAP: begin
          d_ro    = 1'b1;
          d_rdata = SCPM_IN_CAP_RST;
        end
        SCPM_CP_CTRLCAP: begin
          d_ro    = 1'b1;
          d_rdata = CTRL_CAP;
        end
        SCPM_CP_STATCAP: begin
          d_ro    = 1'b1;
          d_rdata = STAT_CAP;
        end
        SCPM_CP_EXTPOS: begin
          d_loc  = 1'b1;
          d_slot = SCPM_SLOT_EXTPOS;
        end
        default: begin
          if (req_q.num[7:0] >= SCPM_CP_INFO_LO &&
              req_q.num[7:0] <= SCPM_CP_INFO_HI) begin
            d_ro    = 1'b1;
            d_rdata = dev_info[4'(req_q.num[7:0] - SCPM_CP_INFO_LO)];
          end else if (req_q.num[7:0] >= SCPM_CP_UNIT_LO &&
                       req_q.num[7:0] <= SCPM_CP_UNIT_HI) begin
            d_loc  = 1'b1;
            d_slot = 4'(req_q.num[7:0] - SCPM_CP_UNIT_LO);
          end else if (req_q.num[7:0] >= SCPM_CP_MON_LO &&
                       req_q.num[7:0] <= SCPM_CP_MON_HI) begin
            d_loc  = 1'b1;
            d_slot = 4'(req_q.num[7:0] - SCPM_CP_MON_LO) + SCPM_SLOT_MON_LO;
          end else begin
            d_err = 1'b1;
          end
        end
      endcase
      if (d_loc) begin
        d_rdata = loc_q[d_slot];
      end
    end
    d_defer = d_mem && (d_pt == SCPM_PT_GEAR_N || d_pt == SCPM_PT_GEAR_D);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cfg_pend_q) begin
            state_q <= S_FLUSH;
          end else if (req_valid) begin
            state_q <= S_EXEC;
          end
        end
        S_EXEC: begin
          state_q <= (d_mem && !req_q.write) ? S_MEMRD : S_IDLE;
        end
        S_MEMRD: begin
          state_q <= S_IDLE;
        end
        S_FLUSH: begin
          if (gear_pend_q == 2'b00) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Request capture, motor kind caught with it
  always_ff @(posedge clk) begin
    if (srst) begin
      req_q <= '0;
      lin_q <= 1'b0;
    end else if (req_fire) begin
      req_q <= req;
      lin_q <= motor_linear;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive parameter storage
  scpm_param_ram #(
    .DEPTH (DEPTH),
    .AW    (SCPM_PT_AW),
    .DW    (32)
  ) u_ram (
    .clk     (clk),
    .en      (state_q == S_EXEC && d_mem),
    .we      (req_q.write),
    .addr    (d_pt),
    .wdata   (req_q.data),
    .rdata_q (mem_rdata)
  );

  // Response: two cycles after accept, three for drive parameter reads
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (state_q == S_EXEC && !(d_mem && !req_q.write)) begin
        rsp_valid_q <= 1'b1;
        rsp_q.err   <= d_err || (req_q.write && d_ro);
        rsp_q.data  <= req_q.write ? 32'h00000000 : d_rdata;
      end else if (state_q == S_MEMRD) begin
        rsp_valid_q <= 1'b1;
        rsp_q.err   <= 1'b0;
        rsp_q.data  <= mem_rdata;
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp       = rsp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Apply port: immediate writes now, staged gear values on config
  always_ff @(posedge clk) begin
    if (srst) begin
      apply_valid_q <= 1'b0;
      apply_q       <= '0;
    end else begin
      apply_valid_q <= 1'b0;
      if (state_q == S_EXEC && d_mem && req_q.write && !d_defer) begin
        apply_valid_q <= 1'b1;
        apply_q.pt    <= d_pt;
        apply_q.data  <= req_q.data;
      end else if (state_q == S_FLUSH && gear_pend_q[0]) begin
        apply_valid_q <= 1'b1;
        apply_q.pt    <= SCPM_PT_GEAR_N;
        apply_q.data  <= gear_stage_q[0];
      end else if (state_q == S_FLUSH && gear_pend_q[1]) begin
        apply_valid_q <= 1'b1;
        apply_q.pt    <= SCPM_PT_GEAR_D;
        apply_q.data  <= gear_stage_q[1];
      end
    end
  end

  assign apply_valid = apply_valid_q;
  assign apply       = apply_q;

  // Deferred staging; flush drains numerator first
  always_ff @(posedge clk) begin
    if (srst) begin
      gear_pend_q     <= 2'b00;
      gear_stage_q[0] <= SCPM_LOC_RST;
      gear_stage_q[1] <= SCPM_LOC_RST;
    end else if (state_q == S_EXEC && d_defer && req_q.write) begin
      gear_pend_q[d_pt == SCPM_PT_GEAR_D]  <= 1'b1;
      gear_stage_q[d_pt == SCPM_PT_GEAR_D] <= req_q.data;
    end else if (state_q == S_FLUSH && gear_pend_q[0]) begin
      gear_pend_q[0] <= 1'b0;
    end else if (state_q == S_FLUSH) begin
      gear_pend_q[1] <= 1'b0;
    end
  end

  // Config request flag; a new config pulse wins over the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_pend_q <= 1'b0;
    end else if (cfg_valid) begin
      cfg_pend_q <= 1'b1;
    end else if (state_q == S_FLUSH && gear_pend_q == 2'b00) begin
      cfg_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Locally served common parameters
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < SCPM_SLOTS; i++) begin
        loc_q[i] <= SCPM_LOC_RST;
      end
    end else if (state_q == S_EXEC && d_loc && req_q.write) begin
      loc_q[d_slot] <= req_q.data;
    end
  end

  assign sel_mon_one = loc_q[SCPM_SLOT_SELMON1];
  assign sel_mon_two = loc_q[SCPM_SLOT_SELMON2];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_rd(logic [15:0] n);
    req_fire && !req.write && req.num == n;
  endsequence

  sequence s_wr(logic [15:0] n);
    req_fire && req.write && req.num == n;
  endsequence

  AST_OUT_CAP: assert property (s_rd(16'h0092) |-> ##2
    rsp_valid && !rsp.err && rsp.data == SCPM_OUT_CAP_RST)
    else $error("output capability word wrong");
  AST_IN_CAP: assert property (s_rd(16'h0093) |-> ##2
    rsp_valid && !rsp.err && rsp.data == SCPM_IN_CAP_RST)
    else $error("input capability word wrong");
  AST_PT_NUMBER: assert property (s_wr(16'h2100) |-> ##2
    apply_valid && apply.pt == 11'h100)
    else $error("bus number not mapped to drive parameter");
  AST_APPLY_CAUSE: assert property (apply_valid |->
    $past(state_q == S_FLUSH) || $past(state_q == S_EXEC && req_q.write))
    else $error("drive parameter changed without a write");
  AST_IMMEDIATE: assert property (s_wr(16'h2102) |-> ##2
    apply_valid && apply.data == $past(req.data, 2))
    else $error("immediate write not applied");
  AST_DEFERRED: assert property (s_wr(16'h220E) |-> ##1 1'b1 ##1
    !apply_valid && gear_pend_q[0])
    else $error("deferred write applied early");
  AST_GEAR_ALIAS: assert property (s_wr(16'h0022) |-> ##2
    gear_pend_q[1] && gear_stage_q[1] == $past(req.data, 2))
    else $error("gear denominator not staged");
  AST_ADJ_ALIAS: assert property (s_wr(16'h0065) |-> ##2
    apply_valid && apply.pt == 11'h11F)
    else $error("adjustment alias wrong");
  AST_HOME_ALIAS: assert property (s_wr(16'h0084) |-> ##2
    apply_valid && apply.pt == ($past(motor_linear, 2) ? 11'h706 : 11'h702))
    else $error("homing alias wrong");
  AST_SPD_ALIAS: assert property (s_wr(16'h008E) |-> ##2
    apply_valid && apply.pt == ($past(motor_linear, 2) ? 11'h581 : 11'h502))
    else $error("speed range alias wrong");
  AST_INFO_RO: assert property (s_wr(16'h0005) |-> ##2
    rsp_valid && rsp.err && !apply_valid)
    else $error("device information write accepted");
  AST_CTRL_CAP: assert property (s_rd(16'h0090) |-> ##2
    rsp_valid && rsp.data == CTRL_CAP)
    else $error("control field capability wrong");
  AST_SEL_MON: assert property (s_wr(16'h0089) |-> ##2
    sel_mon_one == $past(req.data, 2))
    else $error("selectable monitor one not updated");
  AST_RO_REFUSE: assert property (s_wr(16'h0092) |-> ##2
    rsp_valid && rsp.err && rsp.data == 32'h00000000)
    else $error("capability write not refused");

endmodule // scpm_param_bank

`default_nettype wire

// *** rtl/scpm_pkg.sv ***
// Package for the servo common parameter bank: numbers, layouts, types.
// Assumes one clock domain; the bank sits behind the drive's command decoder.
`default_nettype none

package scpm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter numbering
  localparam logic [15:0] SCPM_PT_BASE    = 16'h2000; // Bus number of Pt 0
  localparam int          SCPM_PT_AW      = 11;       // Pt number width
  localparam int          SCPM_PT_DEPTH   = 2048;     // Pt numbers held
  localparam logic [7:0]  SCPM_CP_INFO_LO = 8'h01;
  localparam logic [7:0]  SCPM_CP_INFO_HI = 8'h0C;
  localparam logic [7:0]  SCPM_CP_GEAR_N  = 8'h21;
  localparam logic [7:0]  SCPM_CP_GEAR_D  = 8'h22;
  localparam logic [7:0]  SCPM_CP_UNIT_LO = 8'h41;
  localparam logic [7:0]  SCPM_CP_UNIT_HI = 8'h49;
  localparam logic [7:0]  SCPM_CP_EXTPOS  = 8'h83;
  localparam logic [7:0]  SCPM_CP_MON_LO  = 8'h87;
  localparam logic [7:0]  SCPM_CP_SELMON1 = 8'h89;
  localparam logic [7:0]  SCPM_CP_SELMON2 = 8'h8A;
  localparam logic [7:0]  SCPM_CP_MON_HI  = 8'h8B;
  localparam logic [7:0]  SCPM_CP_CTRLCAP = 8'h90;
  localparam logic [7:0]  SCPM_CP_STATCAP = 8'h91;
  localparam logic [7:0]  SCPM_CP_OUTCAP  = 8'h92;
  localparam logic [7:0]  SCPM_CP_INCAP   = 8'h93;

  // Deferred drive parameters (electronic gear ratio)
  localparam logic [10:0] SCPM_PT_GEAR_N  = 11'h20E;
  localparam logic [10:0] SCPM_PT_GEAR_D  = 11'h210;

  ////////////////////////////////////////////////////////////////////////////
  // Local store slots for common parameters served by the bank itself
  localparam int         SCPM_SLOTS       = 16;
  localparam logic [3:0] SCPM_SLOT_EXTPOS = 4'h9;
  localparam logic [3:0] SCPM_SLOT_MON_LO = 4'hA;
  localparam logic [3:0] SCPM_SLOT_SELMON1 = 4'hC;
  localparam logic [3:0] SCPM_SLOT_SELMON2 = 4'hD;

  ////////////////////////////////////////////////////////////////////////////
  // Capability words and reset values
  localparam logic [31:0] SCPM_OUT_CAP_RST = 32'h00F000C0;
  localparam logic [31:0] SCPM_IN_CAP_RST  = 32'hFFCFF20E;
  localparam logic [31:0] SCPM_LOC_RST     = 32'h00000000;
  localparam int SCPM_OUT_CL_LSB   = 4;  // Current limit / prop ctrl, 4..7
  localparam int SCPM_OUT_GSEL_LSB = 8;  // Gain select, 8..9
  localparam int SCPM_OUT_PORT_LSB = 20; // Outputs 1..4, 20..23
  localparam int SCPM_IN_PORT_LSB  = 24; // Inputs 1..8, 24..31

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        write; // 1: parameter write command, 0: read
    logic [15:0] num;   // Bus parameter number
    logic [31:0] data;  // Write data
  } scpm_req_s;

  typedef struct packed {
    logic        err;   // Command refused
    logic [31:0] data;  // Read data, zero for writes
  } scpm_rsp_s;

  typedef struct packed {
    logic [10:0] pt;    // Drive parameter number
    logic [31:0] data;  // Value now in force
  } scpm_apply_s;

  typedef struct packed {
    logic        hit;
    logic [10:0] pt;
  } scpm_alias_s;

  // Common parameter to drive parameter alias table
  function automatic scpm_alias_s scpm_alias(input logic [7:0] cp,
                                             input logic       lin);
    scpm_alias_s a;
    a.hit = 1'b1;
    a.pt  = 11'h000;
    case (cp)
      SCPM_CP_GEAR_N: a.pt = SCPM_PT_GEAR_N;
      SCPM_CP_GEAR_D: a.pt = SCPM_PT_GEAR_D;
      8'h61: a.pt = 11'h100;
      8'h62: a.pt = 11'h101;
      8'h63: a.pt = 11'h102;
      8'h64: a.pt = 11'h109;
      8'h65: a.pt = 11'h11F;
      8'h66: a.pt = 11'h522;
      8'h67: a.pt = 11'h524;
      8'h84: a.pt = lin ? 11'h706 : 11'h702;
      8'h85: a.pt = lin ? 11'h705 : 11'h701;
      8'h86: a.pt = 11'h704;
      8'h8C: a.pt = 11'h404;
      8'h8D: a.pt = 11'h405;
      8'h8E: a.pt = lin ? 11'h581 : 11'h502;
      8'h8F: a.pt = lin ? 11'h582 : 11'h503;
      default: a.hit = 1'b0;
    endcase
    return a;
  endfunction

endpackage

`default_nettype wire

// *** rtl/scpm_param_ram.sv ***
// Drive parameter storage: one port, synchronous write, registered read.
// Assumes the caller never reads and writes in the same cycle.
`default_nettype none

module scpm_param_ram #(
  parameter int DEPTH = 2048,
  parameter int AW    = 11,
  parameter int DW    = 32
) (
  input  wire logic          clk,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output var  logic [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [DEPTH];

  // Write or read one word per enabled cycle
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
    if (en && !we) begin
      rdata_q <= mem[addr];
    end
  end

endmodule // scpm_param_ram

`default_nettype wire

// *** dv/scpm_host_model.sv ***
// Command master model: issues one parameter read or write at a time.
// Assumes the bank's ready is combinational and settles before negedge.
`default_nettype none

module scpm_host_model
  import scpm_pkg::*;
(
  input  wire logic                clk,
  output var  logic                req_valid,
  output var  scpm_pkg::scpm_req_s req,
  input  wire logic                req_ready,
  input  wire logic                rsp_valid,
  input  wire scpm_pkg::scpm_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold the command until taken, release, then time the answer
  task automatic xfer(input logic w, input logic [15:0] num,
                      input logic [31:0] data, output scpm_rsp_s r,
                      output int lat);
    int n;
    n   = 0;
    lat = -1;
    r   = '0;
    @(negedge clk);
    req_valid = 1'b1;
    req       = '{write: w, num: num, data: data};
    #1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    req       = ~req; // Released lines must not show the old value
    for (n = 0; n < 20 && lat < 0; n++) begin
      if (rsp_valid === 1'b1) begin
        r   = rsp;
        lat = n + 1; // Counted from the accepting edge
      end
      if (lat < 0) @(negedge clk);
    end
  endtask
endmodule // scpm_host_model

`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the servo common parameter bank.
// Assumes the host model drives commands; bench drives config and info.
`default_nettype none

module testbench
  import scpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] CTRL_CAP_T = 32'h0000F0A5;
  localparam logic [31:0] STAT_CAP_T = 32'h00C3003C;
  // Alias table: common number, rotary and linear drive parameter
  localparam logic [7:0]  CPS [16] = '{8'h21, 8'h22, 8'h61, 8'h62, 8'h63,
    8'h64, 8'h65, 8'h66, 8'h67, 8'h84, 8'h85, 8'h86, 8'h8C, 8'h8D, 8'h8E,
    8'h8F};
  localparam logic [10:0] PT_R [16] = '{11'h20E, 11'h210, 11'h100, 11'h101,
    11'h102, 11'h109, 11'h11F, 11'h522, 11'h524, 11'h702, 11'h701, 11'h704,
    11'h404, 11'h405, 11'h502, 11'h503};
  localparam logic [10:0] PT_L [16] = '{11'h20E, 11'h210, 11'h100, 11'h101,
    11'h102, 11'h109, 11'h11F, 11'h522, 11'h524, 11'h706, 11'h705, 11'h704,
    11'h404, 11'h405, 11'h581, 11'h582};

  logic              clk, srst, req_valid, req_ready, rsp_valid;
  logic              cfg_valid, motor_linear, apply_valid;
  scpm_req_s         req;
  scpm_rsp_s         rsp, r;
  scpm_apply_s       apply;
  logic [11:0][31:0] dev_info;
  logic [31:0]       sel_mon_one, sel_mon_two, d, e;
  logic [10:0]       pt;
  int                failures, samples_checked, lat, i, l;
  scpm_apply_s       seen [$];

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Collect every apply pulse
  always @(posedge clk) begin
    if (apply_valid === 1'b1) seen.push_back(apply);
  end

  scpm_param_bank #(.CTRL_CAP(CTRL_CAP_T), .STAT_CAP(STAT_CAP_T)) dut (
    .clk(clk), .srst(srst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .cfg_valid(cfg_valid), .motor_linear(motor_linear),
    .dev_info(dev_info), .apply_valid(apply_valid), .apply(apply),
    .sel_mon_one(sel_mon_one), .sel_mon_two(sel_mon_two));

  scpm_host_model u_host (
    .clk(clk), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp));

  ////////////////////////////////////////////////////////////////////////////
  // Expectations and checks
  function automatic logic [15:0] pt_num(input logic [10:0] p);
    return 16'h2000 + {5'h00, p};
  endfunction

  function automatic logic [10:0] exp_pt(input int k, input int lin);
    return (lin != 0) ? PT_L[k] : PT_R[k];
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One command with its answer, latency and apply pulses
  task automatic cmd(input logic w, input logic [15:0] num,
                     input logic [31:0] wd, input logic err,
                     input logic [31:0] rd, input int elat);
    seen.delete();
    u_host.xfer(w, num, wd, r, lat);
    @(posedge clk);
    #1;
    check(r.err, err, "error flag");
    check(r.data, rd, "answer data");
    check(lat, elat, "answer latency");
  endtask

  task automatic check_apply(input int n, input logic [10:0] p,
                             input logic [31:0] v);
    check(seen.size(), n, "apply count");
    if (n > 0 && seen.size() > 0) begin
      check(seen[0].pt, p, "apply parameter");
      check(seen[0].data, v, "apply data");
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #100000;
    failures++;
    $display("[FAIL] %0t run did not finish", $time);
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    failures = 0;
    samples_checked = 0;
    srst = 1'b1;
    cfg_valid = 1'b0;
    motor_linear = 1'b0;
    void'($urandom(32'h76AF));
    for (i = 0; i < 12; i++) dev_info[i] = $urandom();
    repeat (16) @(negedge clk);
    srst = 1'b0;
    check(req_ready, 1'b1, "ready after reset");
    check(sel_mon_one, 32'h0, "monitor one reset");
    // Capability words, then refused writes leave 92h and 93h unchanged
    cmd(0, 16'h0092, 0, 0, 32'h00F000C0, 2);
    cmd(0, 16'h0093, 0, 0, 32'hFFCFF20E, 2);
    cmd(0, 16'h0090, 0, 0, CTRL_CAP_T, 2);
    cmd(0, 16'h0091, 0, 0, STAT_CAP_T, 2);
    for (i = 'h90; i <= 'h93; i++) cmd(1, 16'(i), $urandom(), 1, 0, 2);
    cmd(0, 16'h0092, 0, 0, 32'h00F000C0, 2);
    cmd(0, 16'h0093, 0, 0, 32'hFFCFF20E, 2);
    // Device information, unit and other local words are served locally
    for (i = 1; i <= 12; i++) cmd(0, 16'(i), 0, 0, dev_info[i-1], 2);
    cmd(1, 16'h0005, 32'h1, 1, 0, 2);
    for (i = 'h41; i <= 'h8B; i++) begin
      if (i > 'h49 && i < 'h87 && i != 'h83) continue;
      d = $urandom();
      cmd(1, 16'(i), d, 0, 0, 2);
      check_apply(0, 0, 0);
      cmd(0, 16'(i), 0, 0, d, 2);
    end
    // Selectable monitor slots
    d = $urandom();
    cmd(1, 16'h0089, d, 0, 0, 2);
    check(sel_mon_one, d, "monitor one");
    d = $urandom();
    cmd(1, 16'h008A, d, 0, 0, 2);
    check(sel_mon_two, d, "monitor two");
    // Drive parameters, top number first, plus unmapped numbers
    for (i = 0; i < 8; i++) begin
      pt = 11'($urandom());
      if (i < 3) pt = (i == 0) ? 11'h7FF : 11'h100 + 11'(2 * i - 2);
      if (pt == 11'h20E || pt == 11'h210) pt = 11'h300;
      d = $urandom();
      cmd(1, pt_num(pt), d, 0, 0, 2);
      check_apply(1, pt, d);
      cmd(0, pt_num(pt), 0, 0, d, 3);
    end
    cmd(0, 16'h2800, 0, 1, 0, 2);
    cmd(0, 16'h0050, 0, 1, 0, 2);
    // Aliased common numbers, both motor kinds
    for (l = 0; l < 2; l++) begin
      @(negedge clk);
      motor_linear = l[0];
      for (i = 2; i < 16; i++) begin
        d = $urandom();
        cmd(1, {8'h00, CPS[i]}, d, 0, 0, 2);
        check_apply(1, exp_pt(i, l), d);
        cmd(0, pt_num(exp_pt(i, l)), 0, 0, d, 3);
        cmd(0, {8'h00, CPS[i]}, 0, 0, d, 3);
      end
    end
    // Gear ratio is deferred until the config command
    d = $urandom();
    e = $urandom();
    cmd(1, pt_num(11'h20E), e, 0, 0, 2);
    check_apply(0, 0, 0);
    cmd(1, 16'h0021, d, 0, 0, 2);
    check_apply(0, 0, 0);
    cmd(1, 16'h0022, e, 0, 0, 2);
    check_apply(0, 0, 0);
    cmd(0, pt_num(11'h20E), 0, 0, d, 3);
    cmd(0, 16'h0022, 0, 0, e, 3);
    seen.delete();
    @(negedge clk);
    cfg_valid = 1'b1;
    @(negedge clk);
    cfg_valid = 1'b0;
    repeat (8) @(negedge clk);
    check(seen.size(), 2, "flush count");
    check(seen[0].pt, 11'h20E, "flush first");
    check(seen[0].data, d, "flush first data");
    check(seen[1].pt, 11'h210, "flush second");
    check(seen[1].data, e, "flush second data");
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire
